// *** sim/adc_conversion_control_sva.sv ***
`timescale 1ns/1ps
module adc_conversion_control_sva #(
    parameter int RESULT_WIDTH = 8
) (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    nrst,
    input wire logic                    ce,
    // Bus
    input wire logic                    cyc_i,
    input wire logic                    stb_i,
    input wire logic                    we_i,
    input wire logic [7:0]              adr_i,
    input wire logic [3:0]              sel_i,
    input wire logic [31:0]             dat_i,
    input wire logic [31:0]             dat_o,
    input wire logic                    ack_o,
    // Power and front end
    input wire logic                    sleep_enter,
    input wire logic                    wake,
    input wire logic                    comp_in,
    input wire logic [RESULT_WIDTH-1:0] dac_code,
    input wire logic                    sample_en,
    input wire logic                    converter_powered,
    input wire logic [1:0]              channel_select,
    input wire logic [1:0]              analog_pin_select,
    input wire logic                    irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_resp; cyc_i && stb_i && !ack_o && ce |=> ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("bus request not answered");
    // Reset itself is the cause here, so this one is never disabled
    property p_reset_vals;
        disable iff (1'b0) !nrst |=> channel_select == 2'b11 && analog_pin_select == 2'b11
            && !converter_powered && !irq && !ack_o;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    property p_sleep_power;
        $rose(sleep_enter) |-> ##[1:2] (!converter_powered && channel_select == 2'b11);
    endproperty
    a_sleep_power: assert property (p_sleep_power) else $error("sleep left power on");
    property p_sleep_pins; $rose(sleep_enter) |=> $stable(analog_pin_select)[*2]; endproperty
    a_sleep_pins: assert property (p_sleep_pins) else $error("sleep changed pins");
    property p_no_conv_sleep; $rose(sleep_enter) |=> ##1 !sample_en[*8]; endproperty
    a_no_conv_sleep: assert property (p_no_conv_sleep) else $error("sampling in sleep");
    property p_sample_power; sample_en |-> converter_powered; endproperty
    a_sample_power: assert property (p_sample_power) else $error("sampling unpowered");
    property p_power_rise; $rose(converter_powered) |-> $past(cyc_i && stb_i && we_i); endproperty
    a_power_rise: assert property (p_power_rise) else $error("power set without write");
    property p_sample_len; $rose(sample_en) |-> sample_en[*8]; endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample period too short");
    property p_irq_fall;
        $fell(irq) |-> $past(cyc_i && we_i, 1) || $past(cyc_i && we_i, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");

    c_done: cover property ($rose(irq));
    c_sleep_busy: cover property ($rose(sleep_enter) && converter_powered);
    c_sample_end: cover property ($fell(sample_en));
endmodule

bind adc_conversion_control adc_conversion_control_sva #(.RESULT_WIDTH(RESULT_WIDTH)) u_sva (
    .clk(clk), .nrst(nrst), .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sleep_enter(sleep_enter), .wake(wake), .comp_in(comp_in), .dac_code(dac_code),
    .sample_en(sample_en), .converter_powered(converter_powered),
    .channel_select(channel_select), .analog_pin_select(analog_pin_select), .irq(irq));

// *** sim/adc_conversion_control_test.sv ***
`timescale 1ns/1ps
module adc_conversion_control_test;
    // ************************************************************
    // Stimulus, design and comparator stand-in
    // ************************************************************
    localparam int DIV  = 20;
    localparam int CONV = 13 * DIV;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        ce = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic        sleep_enter = 1'b0;
    logic        wake = 1'b0;
    logic        comp_in = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [7:0]  dac_code;
    logic        sample_en;
    logic        converter_powered;
    logic [1:0]  channel_select;
    logic [1:0]  analog_pin_select;
    logic        irq;
    logic [7:0]  vin = 8'h00;
    logic [63:0] note;
    logic [63:0] notes[$];
    int          fails = 0;
    int          num_checks = 0;

    always #12.5 clk = ~clk;

    adc_conversion_control uut (
        .clk(clk), .nrst(nrst), .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sleep_enter(sleep_enter), .wake(wake), .comp_in(comp_in), .dac_code(dac_code),
        .sample_en(sample_en), .converter_powered(converter_powered),
        .channel_select(channel_select), .analog_pin_select(analog_pin_select), .irq(irq));

    // Ideal comparator: high while the input is at or above the trial code
    always @(posedge clk) comp_in <= (vin >= dac_code);

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Read data is taken at the very edge at which the master samples ack high
    always @(posedge clk) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && notes.size() > 0) begin
            note = notes.pop_front();
            check("read data", dat_o & note[63:32], note[31:0]);
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        notes.push_back({mask, exp & mask});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic convert(input logic [1:0] chan);
        int cnt;
        cnt = 0;
        vin <= 8'($urandom);
        wr(adc_ctrl_pkg::ADDR_CONTROL, {24'h0, 2'b11, 2'b00, chan, 2'b01});
        // Let the hold capacitor settle on the new channel before starting
        repeat (DIV) @(posedge clk);
        wr(adc_ctrl_pkg::ADDR_CONTROL, {24'h0, 2'b11, 2'b00, chan, 2'b11});
        while (irq !== 1'b1 && cnt < 2 * CONV) begin
            @(negedge clk);
            cnt++;
        end
        check("conversion time", 32'(cnt >= CONV - 2 && cnt <= CONV + 6), 32'h1);
        rd(adc_ctrl_pkg::ADDR_RESULT, {24'h0, vin}, 32'hffff_ffff);
        check("dac code", {24'h0, dac_code}, {24'h0, vin});
        rd(adc_ctrl_pkg::ADDR_CONTROL, 32'h0, 32'h2);
        rd(adc_ctrl_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
        wr(adc_ctrl_pkg::ADDR_IRQ_STAT, 32'h7);
        @(negedge clk);
        check("irq cleared", 32'(irq), 32'h0);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h2088));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check("channel", 32'(channel_select), 32'h3);
        check("pins", 32'(analog_pin_select), 32'h3);
        rd(adc_ctrl_pkg::ADDR_CONTROL, 32'hcc, 32'hcf);
        rd(adc_ctrl_pkg::ADDR_DIVISOR, 32'h20, 32'hffff);
        rd(8'h20, 32'h0, 32'hffff_ffff);
        wr(adc_ctrl_pkg::ADDR_IRQ_MASK, 32'h7);
        wr(adc_ctrl_pkg::ADDR_DIVISOR, 32'(DIV));
        wr(adc_ctrl_pkg::ADDR_CONTROL, 32'hce);
        rd(adc_ctrl_pkg::ADDR_STATUS, 32'h0, 32'h1);
        rd(adc_ctrl_pkg::ADDR_CONTROL, 32'h0, 32'h3);
        for (int i = 0; i < 4; i++) convert(2'(i));
        // Abort well past the sampling period
        wr(adc_ctrl_pkg::ADDR_CONTROL, 32'hcd);
        wr(adc_ctrl_pkg::ADDR_CONTROL, 32'hcf);
        repeat (5 * DIV) @(posedge clk);
        wr(adc_ctrl_pkg::ADDR_CONTROL, 32'hcd);
        rd(adc_ctrl_pkg::ADDR_STATUS, 32'h0, 32'h1);
        rd(adc_ctrl_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
        wr(adc_ctrl_pkg::ADDR_IRQ_STAT, 32'h7);
        convert(2'b01);
        // Sleep in mid conversion with pins at 01 and channel 00
        wr(adc_ctrl_pkg::ADDR_CONTROL, 32'h41);
        wr(adc_ctrl_pkg::ADDR_CONTROL, 32'h43);
        repeat (4 * DIV) @(posedge clk);
        sleep_enter <= 1'b1;
        repeat (3) @(negedge clk);
        check("power", 32'(converter_powered), 32'h0);
        check("channel", 32'(channel_select), 32'h3);
        check("pins", 32'(analog_pin_select), 32'h1);
        rd(adc_ctrl_pkg::ADDR_CONTROL, 32'h4c, 32'hcf);
        rd(adc_ctrl_pkg::ADDR_STATUS, 32'h6, 32'h7);
        rd(adc_ctrl_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
        wr(adc_ctrl_pkg::ADDR_CONTROL, 32'hc3);
        rd(adc_ctrl_pkg::ADDR_CONTROL, 32'h4c, 32'hcf);
        check("irq", 32'(irq), 32'h1);
        wr(adc_ctrl_pkg::ADDR_IRQ_MASK, 32'h0);
        @(negedge clk);
        check("irq masked", 32'(irq), 32'h0);
        wr(adc_ctrl_pkg::ADDR_IRQ_STAT, 32'h7);
        wr(adc_ctrl_pkg::ADDR_IRQ_MASK, 32'h7);
        @(posedge clk);
        sleep_enter <= 1'b0;
        wake <= 1'b1;
        repeat (2) @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(negedge clk);
        check("pins", 32'(analog_pin_select), 32'h3);
        rd(adc_ctrl_pkg::ADDR_CONTROL, 32'hcc, 32'hcf);
        rd(adc_ctrl_pkg::ADDR_STATUS, 32'h0, 32'h2);
        convert(2'b10);
        print_verdict();
    end
endmodule

// *** verilog/adc_conversion_control.sv ***
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module adc_conversion_control #(
    parameter int RESULT_WIDTH = adc_ctrl_pkg::RESULT_WIDTH
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    // Wishbone slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic [31:0]                  dat_o,
    output logic                         ack_o,
    // Power state
    input  wire logic                    sleep_enter,
    input  wire logic                    wake,
    // Analog front end
    input  wire logic                    comp_in,
    output logic [RESULT_WIDTH-1:0]      dac_code,
    output logic                         sample_en,
    output logic                         converter_powered,
    output logic [1:0]                   channel_select,
    output logic [1:0]                   analog_pin_select,
    // Interrupt
    output logic                         irq
);
    // ************************************************************
    // Input synchronisation
    // ************************************************************
    logic comp_meta;
    logic comp_sync;
    logic next_comp_meta;
    logic next_comp_sync;

    always_comb begin
        next_comp_meta = comp_in;
        next_comp_sync = comp_meta;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else if (ce) begin
            comp_meta <= next_comp_meta;
            comp_sync <= next_comp_sync;
        end
    end

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic bus_req;
    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
    logic wr_div;

    assign bus_req  = cyc_i && stb_i && !ack_o;
    assign wr_ctrl  = bus_req && we_i && sel_i[0] && (adr_i == adc_ctrl_pkg::ADDR_CONTROL);
    assign wr_istat = bus_req && we_i && sel_i[0] && (adr_i == adc_ctrl_pkg::ADDR_IRQ_STAT);
    assign wr_imask = bus_req && we_i && sel_i[0] && (adr_i == adc_ctrl_pkg::ADDR_IRQ_MASK);
    assign wr_div   = bus_req && we_i && (adr_i == adc_ctrl_pkg::ADDR_DIVISOR);

    // ************************************************************
    // Control state
    // ************************************************************
    adc_ctrl_pkg::conv_state_t state;
    adc_ctrl_pkg::conv_state_t next_state;
    logic        go;
    logic        next_go;
    logic        power_on;
    logic        next_power_on;
    logic [1:0]  chan;
    logic [1:0]  next_chan;
    logic [1:0]  pins;
    logic [1:0]  next_pins;
    logic        asleep;
    logic        next_asleep;
    logic [15:0] divisor;
    logic [15:0] next_divisor;
    logic [3:0]  period_cnt;
    logic [3:0]  next_period_cnt;
    logic        ev_done;
    logic        ev_abort;
    logic        ev_sleep;
    logic        sar_clear;
    logic        sar_step;
    logic        tick;
    logic        sar_resolved;
    logic [RESULT_WIDTH-1:0] sar_result;
    logic [RESULT_WIDTH-1:0] sar_trial;
    logic        go_wr_one;

    assign go_wr_one = wr_ctrl && dat_i[adc_ctrl_pkg::CTRL_GO_BIT];

    always_comb begin
        next_state      = state;
        next_go         = go;
        next_power_on   = power_on;
        next_chan       = chan;
        next_pins       = pins;
        next_asleep     = asleep;
        next_divisor    = divisor;
        next_period_cnt = period_cnt;
        ev_done         = 1'b0;
        ev_abort        = 1'b0;
        ev_sleep        = 1'b0;
        sar_clear       = 1'b0;
        sar_step        = 1'b0;

        if (wr_div) begin
            // Divisor below the least bit period is lifted to keep accuracy
            if (dat_i[15:0] < 16'(adc_ctrl_pkg::DIV_MIN)) begin
                next_divisor = 16'(adc_ctrl_pkg::DIV_MIN);
            end else begin
                next_divisor = dat_i[15:0];
            end
        end

        if (wr_ctrl && !asleep) begin
            next_power_on = dat_i[adc_ctrl_pkg::CTRL_POWER_BIT];
            next_chan     = dat_i[adc_ctrl_pkg::CTRL_CHAN_LSB +: 2];
            next_pins     = dat_i[adc_ctrl_pkg::CTRL_PINS_LSB +: 2];
            // Start needs power on before this write; a write turning power off also aborts
            next_go = go_wr_one && power_on && next_power_on;
        end

        case (state)
            adc_ctrl_pkg::ST_IDLE: begin
                next_period_cnt = 4'h0;
                if (next_go && !go) begin
                    next_state = adc_ctrl_pkg::ST_SAMPLE;
                end
            end
            adc_ctrl_pkg::ST_SAMPLE, adc_ctrl_pkg::ST_CONVERT: begin
                if (!next_go) begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                    ev_abort   = 1'b1;
                end else if (tick) begin
                    sar_clear       = (state == adc_ctrl_pkg::ST_SAMPLE);
                    sar_step        = (state == adc_ctrl_pkg::ST_CONVERT);
                    next_state      = adc_ctrl_pkg::ST_CONVERT;
                    next_period_cnt = period_cnt + 4'h1;
                    if (period_cnt == 4'(adc_ctrl_pkg::BIT_PERIODS - 1)) begin
                        next_go    = 1'b0;
                        next_state = adc_ctrl_pkg::ST_IDLE;
                        ev_done    = 1'b1;
                    end
                end
            end
            default: begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase

        if (sleep_enter && !asleep) begin
            next_asleep   = 1'b1;
            next_go       = 1'b0;
            next_power_on = 1'b0;
            next_chan     = adc_ctrl_pkg::CHAN_DEFAULT;
            next_pins     = pins;
            next_state    = adc_ctrl_pkg::ST_IDLE;
            ev_sleep      = (state != adc_ctrl_pkg::ST_IDLE);
            ev_abort      = 1'b0;
            ev_done       = 1'b0;
            sar_step      = 1'b0;
        end else if (wake && asleep) begin
            next_asleep   = 1'b0;
            next_go       = 1'b0;
            next_power_on = 1'b0;
            next_chan     = adc_ctrl_pkg::CHAN_DEFAULT;
            next_pins     = adc_ctrl_pkg::PINS_DEFAULT;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state      <= adc_ctrl_pkg::ST_IDLE;
            go         <= 1'b0;
            power_on   <= 1'b0;
            chan       <= adc_ctrl_pkg::CHAN_DEFAULT;
            pins       <= adc_ctrl_pkg::PINS_DEFAULT;
            asleep     <= 1'b0;
            divisor    <= adc_ctrl_pkg::DIV_RESET;
            period_cnt <= 4'h0;
        end else if (ce) begin
            state      <= next_state;
            go         <= next_go;
            power_on   <= next_power_on;
            chan       <= next_chan;
            pins       <= next_pins;
            asleep     <= next_asleep;
            divisor    <= next_divisor;
            period_cnt <= next_period_cnt;
        end
    end

    // ************************************************************
    // Bit period and approximation
    // ************************************************************
    // Bit period is the system clock divided down; there is no private oscillator
    bit_period_timer u_timer (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .run     (state != adc_ctrl_pkg::ST_IDLE),
        .divisor (divisor),
        .tick    (tick)
    );

    // First period samples, then one bit per period; result kept on abort, and on sleep except when sleep meets the tick that ends sampling
    sar_engine #(
        .WIDTH (RESULT_WIDTH)
    ) u_sar (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .clear     (sar_clear),
        .step      (sar_step),
        .bit_index (period_cnt - 4'h1),
        .comp_high (comp_sync),
        .result    (sar_result),
        .trial     (sar_trial),
        .resolved  (sar_resolved)
    );

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [2:0] irq_stat;
    logic [2:0] next_irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] next_irq_mask;
    logic [2:0] irq_events;

    assign irq_events = {ev_sleep, ev_abort, ev_done};

    // Set wins over a write-one clear in the same cycle
    always_comb begin
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (wr_istat) begin
            next_irq_stat = irq_stat & ~dat_i[2:0];
        end
        if (ce) begin
            next_irq_stat = next_irq_stat | irq_events;
        end
        if (wr_imask) begin
            next_irq_mask = dat_i[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            irq      <= 1'b0;
        end else if (ce) begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq      <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ************************************************************
    // Bus answer
    // ************************************************************
    logic [31:0] rd_data;
    logic [31:0] next_dat;
    logic        next_ack;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (adr_i == adc_ctrl_pkg::ADDR_CONTROL) begin
            rd_data[adc_ctrl_pkg::CTRL_POWER_BIT]   = power_on;
            rd_data[adc_ctrl_pkg::CTRL_GO_BIT]      = go;
            rd_data[adc_ctrl_pkg::CTRL_CHAN_LSB +: 2] = chan;
            rd_data[adc_ctrl_pkg::CTRL_PINS_LSB +: 2] = pins;
        end else if (adr_i == adc_ctrl_pkg::ADDR_RESULT) begin
            rd_data[RESULT_WIDTH-1:0] = sar_result;
        end else if (adr_i == adc_ctrl_pkg::ADDR_STATUS) begin
            rd_data[adc_ctrl_pkg::STAT_BUSY_BIT]  = (state != adc_ctrl_pkg::ST_IDLE);
            rd_data[adc_ctrl_pkg::STAT_SLEEP_BIT] = asleep;
            rd_data[2]                            = sar_resolved;
        end else if (adr_i == adc_ctrl_pkg::ADDR_IRQ_STAT) begin
            rd_data[2:0] = irq_stat;
        end else if (adr_i == adc_ctrl_pkg::ADDR_IRQ_MASK) begin
            rd_data[2:0] = irq_mask;
        end else if (adr_i == adc_ctrl_pkg::ADDR_DIVISOR) begin
            rd_data[15:0] = divisor;
        end
        next_ack = bus_req;
        next_dat = bus_req ? rd_data : dat_o;
    end

    // Unmapped addresses still ack, reading zero and ignoring writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce) begin
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

    // ************************************************************
    // Analog front end drive
    // ************************************************************
    // Hold capacitor is left charged between conversions: no discharge phase
    assign sample_en         = (state == adc_ctrl_pkg::ST_SAMPLE);
    assign dac_code          = sar_trial;
    assign converter_powered = power_on;
    assign channel_select    = chan;
    assign analog_pin_select = pins;
endmodule

// *** verilog/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_RESULT    = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;
    localparam logic [7:0] ADDR_DIVISOR   = 8'h14;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int CTRL_POWER_BIT     = 0;
    localparam int CTRL_GO_BIT        = 1;
    localparam int CTRL_CHAN_LSB      = 2;
    localparam int CTRL_PINS_LSB      = 6;
    localparam int SEL_WIDTH          = 2;
    localparam logic [1:0] CHAN_DEFAULT = 2'h3;
    localparam logic [1:0] PINS_DEFAULT = 2'h3;

    // ************************************************************
    // Status and interrupt fields
    // ************************************************************
    localparam int STAT_BUSY_BIT      = 0;
    localparam int STAT_SLEEP_BIT     = 1;
    localparam int IRQ_DONE_BIT       = 0;
    localparam int IRQ_ABORT_BIT      = 1;
    localparam int IRQ_SLEEP_BIT      = 2;
    localparam int IRQ_WIDTH          = 3;

    // ************************************************************
    // Conversion timing
    // ************************************************************
    localparam int RESULT_WIDTH       = 8;
    localparam int BIT_PERIODS        = 13;
    localparam int CLK_PERIOD_NS      = 25;
    localparam int BIT_PERIOD_MIN_NS  = 500;
    // Smallest divisor keeping one bit period at or above its least time
    localparam int DIV_MIN            = (BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] DIV_RESET = 16'h0020;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } conv_state_t;

endpackage

// *** verilog/bit_period_timer.sv ***
`timescale 1ns/1ps
module bit_period_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Control
    input  wire logic        run,
    input  wire logic [15:0] divisor,
    // Tick out
    output logic             tick
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic        next_tick;

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (!run) begin
            next_count = 16'h0000;
        end else if (count + 16'h0001 >= divisor) begin
            next_count = 16'h0000;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule

// *** verilog/sar_engine.sv ***
`timescale 1ns/1ps
module sar_engine #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // Control
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic [3:0]       bit_index,
    input  wire logic             comp_high,
    // Result
    output logic [WIDTH-1:0]      result,
    output logic [WIDTH-1:0]      trial,
    output logic                  resolved
);
    logic [WIDTH-1:0] next_result;
    logic             next_resolved;
    logic [WIDTH-1:0] mask;

    // One trial bit per step, MSB first
    always_comb begin
        mask = '0;
        if (bit_index < 4'(WIDTH)) begin
            mask[WIDTH-1-bit_index] = 1'b1;
        end
        trial         = result | mask;
        next_result   = result;
        next_resolved = resolved;
        if (clear) begin
            next_resolved = 1'b0;
        end else if (step && (mask != '0)) begin
            next_result   = comp_high ? trial : (result & ~mask);
            next_resolved = 1'b1;
        end
    end

    // Result is not cleared between conversions, so an aborted one leaves a partial value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            result   <= '0;
            resolved <= 1'b0;
        end else if (ce) begin
            result   <= clear ? '0 : next_result;
            resolved <= next_resolved;
        end
    end
endmodule
